// *** hw/bmau_cfg.svh ***
// constants of the bcd mantissa arithmetic unit
`ifndef BMAU_CFG_SVH
`define BMAU_CFG_SVH
`define BMAU_ADDR_W 4
`define BMAU_DATA_W 32
`define BMAU_WORD_W 16
`define BMAU_DIGITS 12
`define BMAU_MANT_W 48
`define BMAU_IRQ_W 2
`define BMAU_REG_OP1_EXP 4'h0
`define BMAU_REG_OP1_MHI 4'h1
`define BMAU_REG_OP1_MMID 4'h2
`define BMAU_REG_OP1_MLO 4'h3
`define BMAU_REG_OP2_EXP 4'h4
`define BMAU_REG_OP2_MHI 4'h5
`define BMAU_REG_OP2_MMID 4'h6
`define BMAU_REG_OP2_MLO 4'h7
`define BMAU_REG_ACC_A 4'h8
`define BMAU_REG_ACC_B 4'h9
`define BMAU_REG_CMD 4'hA
`define BMAU_REG_IRQ_STAT 4'hB
`define BMAU_REG_IRQ_MASK 4'hC
`define BMAU_MANT_HI 47:32
`define BMAU_MANT_MID 31:16
`define BMAU_MANT_LO 15:0
`define BMAU_NIBBLE 3:0
`define BMAU_CMD_FIELD 2:0
`define BMAU_IRQ_FIELD 1:0
`define BMAU_IRQ_DONE 0
`define BMAU_IRQ_CARRY 1
`define BMAU_DIGIT_MAX 4'h9
`define BMAU_DIGIT_ADJ 5'h06
`define BMAU_NIB_ONE 4'h1
`define BMAU_NIB_FULL 4'hF
`define BMAU_MUL_STEPS 4'hF
`endif

// *** hw/bmau_pkg.sv ***
// types of the bcd mantissa arithmetic unit
`include "bmau_cfg.svh"
package bmau_pkg;
  typedef enum logic [2:0] {
    BMAU_OP_NONE = 3'h0,
    BMAU_COMPLEMENT_SECOND_OPERAND = 3'h1,
    BMAU_CLEAR_DECIMAL_CARRY = 3'h2,
    BMAU_FIXED_POINT_ADD = 3'h3,
    BMAU_MANTISSA_WORD_ADD = 3'h4,
    BMAU_FAST_MULTIPLY_STEP = 3'h5,
    BMAU_SIGNED_BINARY_MULTIPLY = 3'h6,
    BMAU_FAST_DIVIDE_STEP = 3'h7
  } bmau_op_t;
  typedef enum logic [2:0] {
    BMAU_ST_IDLE = 3'b001,
    BMAU_ST_BCD = 3'b010,
    BMAU_ST_MUL = 3'b100
  } bmau_state_t;
  typedef struct packed {
    logic [`BMAU_WORD_W-1:0] sign_exp;
    logic [`BMAU_MANT_W-1:0] mant;
  } bmau_operand_t;
  typedef struct packed {
    logic [`BMAU_ADDR_W-1:0] addr;
    logic rd;
    logic wr;
    logic [`BMAU_DATA_W-1:0] wdata;
  } bmau_bus_req_t;
endpackage

// *** hw/bmau_unit.sv ***
// bcd mantissa arithmetic unit with avalon-mm register slave
`timescale 1ns/1ps
`default_nettype none
`include "bmau_cfg.svh"

// one decimal digit adder, optional nine's complement of operand a
module bmau_bcd_digit (
  input wire logic [3:0] a,
  input wire logic [3:0] b,
  input wire logic inv_a,
  input wire logic cin,
  output logic [3:0] s,
  output logic cout
);
  logic [3:0] a_eff;
  logic [4:0] raw;
  logic [4:0] adj;

  // nine's complement then binary add, decimal correction above nine
  assign a_eff = inv_a ? (`BMAU_DIGIT_MAX - a) : a;
  assign raw = {1'b0, a_eff} + {1'b0, b} + {4'h0, cin};
  assign cout = raw > {1'b0, `BMAU_DIGIT_MAX};
  assign adj = raw + `BMAU_DIGIT_ADJ;
  assign s = cout ? adj[3:0] : raw[3:0];
endmodule

module bmau_unit (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [`BMAU_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [`BMAU_DATA_W-1:0] avs_writedata,
  output logic [`BMAU_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq
);
  bmau_pkg::bmau_state_t state_r;
  bmau_pkg::bmau_state_t state_nxt;
  bmau_pkg::bmau_op_t op_r;
  bmau_pkg::bmau_op_t op_nxt;
  bmau_pkg::bmau_op_t cmd_op;
  bmau_pkg::bmau_operand_t op1_r;
  bmau_pkg::bmau_operand_t op1_nxt;
  bmau_pkg::bmau_operand_t op2_r;
  bmau_pkg::bmau_operand_t op2_nxt;
  bmau_pkg::bmau_bus_req_t req;
  logic dc_r;
  logic dc_nxt;
  logic [`BMAU_WORD_W-1:0] acc_a_r;
  logic [`BMAU_WORD_W-1:0] acc_a_nxt;
  logic [`BMAU_WORD_W-1:0] acc_b_r;
  logic [`BMAU_WORD_W-1:0] acc_b_nxt;
  logic [`BMAU_WORD_W-1:0] mcand_r;
  logic [`BMAU_WORD_W-1:0] mcand_nxt;
  logic [2*`BMAU_WORD_W:0] mul_r;
  logic [2*`BMAU_WORD_W:0] mul_nxt;
  logic [3:0] rep_r;
  logic [3:0] rep_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [`BMAU_IRQ_W-1:0] irq_stat_r;
  logic [`BMAU_IRQ_W-1:0] irq_mask_r;
  logic [`BMAU_IRQ_W-1:0] irq_set;
  logic rd_ack_r;
  logic [`BMAU_DATA_W-1:0] readdata_r;
  logic [`BMAU_DATA_W-1:0] rd_mux;
  logic [`BMAU_WORD_W-1:0] wdata16;
  logic busy;
  logic wr_take;
  logic rd_take;
  logic rd_launch;
  logic done_ev;
  logic sel_op1_exp;
  logic sel_op1_mhi;
  logic sel_op1_mmid;
  logic sel_op1_mlo;
  logic sel_op2_exp;
  logic sel_op2_mhi;
  logic sel_op2_mmid;
  logic sel_op2_mlo;
  logic sel_acc_a;
  logic sel_acc_b;
  logic sel_cmd;
  logic sel_irq_stat;
  logic sel_irq_mask;
  logic [`BMAU_MANT_W-1:0] add_a;
  logic [`BMAU_MANT_W-1:0] add_b;
  logic add_inv;
  logic add_cin;
  logic [`BMAU_MANT_W-1:0] sum;
  logic [`BMAU_DIGITS:0] carry;
  logic sum_ovf;
  logic [3:0] fmp_cnt;
  logic [3:0] fdv_cnt;
  logic [`BMAU_WORD_W:0] booth_sum;
  logic [`BMAU_WORD_W:0] mcand_ext;

  // bus request bundle and address decode
  assign req = '{addr: avs_address, rd: avs_read, wr: avs_write, wdata: avs_writedata};
  assign wdata16 = req.wdata[`BMAU_WORD_W-1:0];
  assign cmd_op = bmau_pkg::bmau_op_t'(req.wdata[`BMAU_CMD_FIELD]);
  assign sel_op1_exp = req.addr == `BMAU_REG_OP1_EXP;
  assign sel_op1_mhi = req.addr == `BMAU_REG_OP1_MHI;
  assign sel_op1_mmid = req.addr == `BMAU_REG_OP1_MMID;
  assign sel_op1_mlo = req.addr == `BMAU_REG_OP1_MLO;
  assign sel_op2_exp = req.addr == `BMAU_REG_OP2_EXP;
  assign sel_op2_mhi = req.addr == `BMAU_REG_OP2_MHI;
  assign sel_op2_mmid = req.addr == `BMAU_REG_OP2_MMID;
  assign sel_op2_mlo = req.addr == `BMAU_REG_OP2_MLO;
  assign sel_acc_a = req.addr == `BMAU_REG_ACC_A;
  assign sel_acc_b = req.addr == `BMAU_REG_ACC_B;
  assign sel_cmd = req.addr == `BMAU_REG_CMD;
  assign sel_irq_stat = req.addr == `BMAU_REG_IRQ_STAT;
  assign sel_irq_mask = req.addr == `BMAU_REG_IRQ_MASK;

  // handshake: stall everything while busy, reads take one extra cycle
  assign busy = state_r != bmau_pkg::BMAU_ST_IDLE;
  assign wr_take = req.wr & ~busy;
  assign rd_launch = req.rd & ~busy & ~rd_ack_r;
  assign rd_take = req.rd & rd_ack_r;
  assign avs_waitrequest = busy | (req.rd & ~rd_ack_r);
  assign avs_readdata = readdata_r;

  // read mux, unmapped words read zero
  always_comb begin
    rd_mux = '0;
    case (1'b1)
      sel_op1_exp: rd_mux[`BMAU_WORD_W-1:0] = op1_r.sign_exp;
      sel_op1_mhi: rd_mux[`BMAU_WORD_W-1:0] = op1_r.mant[`BMAU_MANT_HI];
      sel_op1_mmid: rd_mux[`BMAU_WORD_W-1:0] = op1_r.mant[`BMAU_MANT_MID];
      sel_op1_mlo: rd_mux[`BMAU_WORD_W-1:0] = op1_r.mant[`BMAU_MANT_LO];
      sel_op2_exp: rd_mux[`BMAU_WORD_W-1:0] = op2_r.sign_exp;
      sel_op2_mhi: rd_mux[`BMAU_WORD_W-1:0] = op2_r.mant[`BMAU_MANT_HI];
      sel_op2_mmid: rd_mux[`BMAU_WORD_W-1:0] = op2_r.mant[`BMAU_MANT_MID];
      sel_op2_mlo: rd_mux[`BMAU_WORD_W-1:0] = op2_r.mant[`BMAU_MANT_LO];
      sel_acc_a: rd_mux[`BMAU_WORD_W-1:0] = acc_a_r;
      sel_acc_b: rd_mux[`BMAU_WORD_W-1:0] = acc_b_r;
      sel_cmd: rd_mux[1:0] = {busy, dc_r};
      sel_irq_stat: rd_mux[`BMAU_IRQ_FIELD] = irq_stat_r;
      sel_irq_mask: rd_mux[`BMAU_IRQ_FIELD] = irq_mask_r;
      default: rd_mux = '0;
    endcase
  end

  // adder operand selection per instruction
  always_comb begin
    add_a = op1_r.mant;
    add_b = op2_r.mant;
    add_inv = 1'b0;
    add_cin = dc_r; // carry enters at digit twelve
    case (op_r)
      bmau_pkg::BMAU_COMPLEMENT_SECOND_OPERAND: begin
        add_a = op2_r.mant; // nine's complement plus one
        add_b = '0;
        add_inv = 1'b1;
        add_cin = 1'b1;
      end
      bmau_pkg::BMAU_MANTISSA_WORD_ADD: begin
        add_a = {{(`BMAU_MANT_W-`BMAU_WORD_W){1'b0}}, acc_b_r}; // digits nine..twelve
      end
      default: begin
        add_a = op1_r.mant;
      end
    endcase
  end

  // twelve digit chain, digit twelve lowest, carry toward digit one
  assign carry[0] = add_cin;
  genvar gi;
  generate
    for (gi = 0; gi < `BMAU_DIGITS; gi = gi + 1) begin : g_dig
      bmau_bcd_digit u_dig (
        .a(add_a[4*gi+3:4*gi]),
        .b(add_b[4*gi+3:4*gi]),
        .inv_a(add_inv),
        .cin(carry[gi]),
        .s(sum[4*gi+3:4*gi]),
        .cout(carry[gi+1])
      );
    end
  endgenerate
  assign sum_ovf = carry[`BMAU_DIGITS];

  // counters for the repeated-add steps
  assign fmp_cnt = cnt_r + {3'h0, sum_ovf};
  assign fdv_cnt = cnt_r + `BMAU_NIB_ONE;

  // booth radix-2 step on sign-extended upper half
  assign mcand_ext = {mcand_r[`BMAU_WORD_W-1], mcand_r};
  always_comb begin
    booth_sum = {mul_r[2*`BMAU_WORD_W], mul_r[2*`BMAU_WORD_W:`BMAU_WORD_W+1]};
    case (mul_r[1:0])
      2'b01: booth_sum = booth_sum + mcand_ext;
      2'b10: booth_sum = booth_sum - mcand_ext;
      default: booth_sum = booth_sum;
    endcase
  end

  // sequencer and register next values
  always_comb begin
    state_nxt = state_r;
    op_nxt = op_r;
    op1_nxt = op1_r;
    op2_nxt = op2_r;
    dc_nxt = dc_r;
    acc_a_nxt = acc_a_r;
    acc_b_nxt = acc_b_r;
    mcand_nxt = mcand_r;
    mul_nxt = mul_r;
    rep_nxt = rep_r;
    cnt_nxt = cnt_r;
    done_ev = 1'b0;
    case (state_r)
      bmau_pkg::BMAU_ST_IDLE: begin
        if (wr_take & sel_op1_exp) op1_nxt.sign_exp = wdata16;
        if (wr_take & sel_op1_mhi) op1_nxt.mant[`BMAU_MANT_HI] = wdata16;
        if (wr_take & sel_op1_mmid) op1_nxt.mant[`BMAU_MANT_MID] = wdata16;
        if (wr_take & sel_op1_mlo) op1_nxt.mant[`BMAU_MANT_LO] = wdata16;
        if (wr_take & sel_op2_exp) op2_nxt.sign_exp = wdata16;
        if (wr_take & sel_op2_mhi) op2_nxt.mant[`BMAU_MANT_HI] = wdata16;
        if (wr_take & sel_op2_mmid) op2_nxt.mant[`BMAU_MANT_MID] = wdata16;
        if (wr_take & sel_op2_mlo) op2_nxt.mant[`BMAU_MANT_LO] = wdata16;
        if (wr_take & sel_acc_a) acc_a_nxt = wdata16;
        if (wr_take & sel_acc_b) acc_b_nxt = wdata16;
        if (wr_take & sel_cmd) begin
          op_nxt = cmd_op;
          cnt_nxt = '0;
          case (cmd_op)
            bmau_pkg::BMAU_CLEAR_DECIMAL_CARRY: begin
              dc_nxt = 1'b0; // nothing else moves
              done_ev = 1'b1;
            end
            bmau_pkg::BMAU_COMPLEMENT_SECOND_OPERAND,
            bmau_pkg::BMAU_FIXED_POINT_ADD,
            bmau_pkg::BMAU_MANTISSA_WORD_ADD,
            bmau_pkg::BMAU_FAST_DIVIDE_STEP: begin
              state_nxt = bmau_pkg::BMAU_ST_BCD;
            end
            bmau_pkg::BMAU_FAST_MULTIPLY_STEP: begin
              rep_nxt = acc_b_r[`BMAU_NIBBLE];
              if (acc_b_r[`BMAU_NIBBLE] == '0) begin
                acc_a_nxt = '0; // no adds, no overflows
                done_ev = 1'b1;
              end else begin
                state_nxt = bmau_pkg::BMAU_ST_BCD;
              end
            end
            bmau_pkg::BMAU_SIGNED_BINARY_MULTIPLY: begin
              mcand_nxt = acc_a_r;
              mul_nxt = {{`BMAU_WORD_W{1'b0}}, acc_b_r, 1'b0};
              rep_nxt = `BMAU_MUL_STEPS;
              state_nxt = bmau_pkg::BMAU_ST_MUL;
            end
            default: begin
              op_nxt = bmau_pkg::BMAU_OP_NONE;
            end
          endcase
        end
      end
      bmau_pkg::BMAU_ST_BCD: begin
        op2_nxt.mant = sum; // sign and exponent word untouched
        dc_nxt = sum_ovf; // overflow out of digit one
        case (op_r)
          bmau_pkg::BMAU_COMPLEMENT_SECOND_OPERAND: begin
            dc_nxt = 1'b0;
            done_ev = 1'b1;
            state_nxt = bmau_pkg::BMAU_ST_IDLE;
          end
          bmau_pkg::BMAU_FAST_MULTIPLY_STEP: begin
            cnt_nxt = fmp_cnt; // one add per cycle, counting overflows
            rep_nxt = rep_r - `BMAU_NIB_ONE;
            if (rep_r == `BMAU_NIB_ONE) begin
              acc_a_nxt = {{(`BMAU_WORD_W-4){1'b0}}, fmp_cnt};
              done_ev = 1'b1;
              state_nxt = bmau_pkg::BMAU_ST_IDLE;
            end
          end
          bmau_pkg::BMAU_FAST_DIVIDE_STEP: begin
            dc_nxt = 1'b0;
            cnt_nxt = fdv_cnt; // add until the first overflow or the fifteenth add
            if (sum_ovf | (fdv_cnt == `BMAU_NIB_FULL)) begin
              acc_b_nxt = '0;
              acc_b_nxt[`BMAU_NIBBLE] = sum_ovf ? cnt_r : fdv_cnt;
              done_ev = 1'b1;
              state_nxt = bmau_pkg::BMAU_ST_IDLE;
            end
          end
          default: begin
            done_ev = 1'b1; // single add, fixed-point or word
            state_nxt = bmau_pkg::BMAU_ST_IDLE;
          end
        endcase
      end
      bmau_pkg::BMAU_ST_MUL: begin
        mul_nxt = {booth_sum, mul_r[`BMAU_WORD_W:1]};
        rep_nxt = rep_r - `BMAU_NIB_ONE;
        if (rep_r == '0) begin
          acc_b_nxt = booth_sum[`BMAU_WORD_W:1]; // sign and upper half
          acc_a_nxt = {booth_sum[0], mul_r[`BMAU_WORD_W:2]}; // lower half
          done_ev = 1'b1;
          state_nxt = bmau_pkg::BMAU_ST_IDLE;
        end
      end
      default: begin
        state_nxt = bmau_pkg::BMAU_ST_IDLE;
      end
    endcase
  end

  // interrupt events: completion and carry left set
  assign irq_set[`BMAU_IRQ_DONE] = done_ev;
  assign irq_set[`BMAU_IRQ_CARRY] = done_ev & dc_nxt;
  assign irq = |(irq_stat_r & irq_mask_r);

  // sequencer state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= bmau_pkg::BMAU_ST_IDLE;
      op_r <= bmau_pkg::BMAU_OP_NONE;
      rep_r <= '0;
      cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      rep_r <= rep_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // operand and accumulator registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      op1_r <= '0;
      op2_r <= '0;
      dc_r <= 1'b0;
      acc_a_r <= '0;
      acc_b_r <= '0;
    end else begin
      op1_r <= op1_nxt;
      op2_r <= op2_nxt;
      dc_r <= dc_nxt;
      acc_a_r <= acc_a_nxt;
      acc_b_r <= acc_b_nxt;
    end
  end

  // booth working registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mcand_r <= '0;
      mul_r <= '0;
    end else begin
      mcand_r <= mcand_nxt;
      mul_r <= mul_nxt;
    end
  end

  // read pipeline: data captured at the same edge that drops waitrequest
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ack_r <= 1'b0;
      readdata_r <= '0;
    end else begin
      rd_ack_r <= rd_launch;
      if (rd_launch) readdata_r <= rd_mux;
    end
  end

  // sticky status cleared by its read, a new event wins; mask by write
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
    end else begin
      irq_stat_r <= (rd_take & sel_irq_stat) ? irq_set : (irq_stat_r | irq_set);
      if (wr_take & sel_irq_mask) irq_mask_r <= req.wdata[`BMAU_IRQ_FIELD];
    end
  end
endmodule
`default_nettype wire

// *** sim/bmau_core_model.sv ***
// avalon-mm master standing in for the processor core that issues instructions
`timescale 1ns/1ps
`default_nettype none
`include "bmau_cfg.svh"
module bmau_core_model (
  input wire logic ref_clk,
  output logic [`BMAU_ADDR_W-1:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [`BMAU_DATA_W-1:0] avs_writedata,
  input wire logic [`BMAU_DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest
);
  // idle bus from time zero
  initial begin
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
  end
  // one transfer, raised after an edge and held until waitrequest is seen low
  task automatic xfer(input logic rd, input logic [3:0] adr, input logic [15:0] wd,
                      output logic [15:0] rdat);
    @(posedge ref_clk);
    avs_read <= rd;
    avs_write <= ~rd;
    avs_address <= adr;
    avs_writedata <= {16'h0000, wd};
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge ref_clk);
    end
    rdat = avs_readdata[15:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // released lines are scrambled so nothing leans on stale values
    avs_address <= ~adr;
    avs_writedata <= ~avs_writedata;
  endtask
endmodule
`default_nettype wire

// *** sim/bmau_unit_monitor.sv ***
// concurrent checks on the register bus of the bcd mantissa arithmetic unit
`timescale 1ns/1ps
`default_nettype none
`include "bmau_cfg.svh"
module bmau_unit_monitor (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [`BMAU_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [`BMAU_DATA_W-1:0] avs_writedata,
  input wire logic [`BMAU_DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // accepted transfers, cycles with no transfer accepted (idle or stalled) and reads that are not left waiting
  wire wr_ok = avs_write && !avs_waitrequest;
  wire rd_ok = avs_read && !avs_waitrequest;
  wire held = !(avs_read || avs_write) || avs_waitrequest;
  wire rd_free = !avs_read || !avs_waitrequest;
  // command accepted, then one busy cycle and a read answered right after
  sequence s_cmd(logic [2:0] code);
    wr_ok && avs_address == `BMAU_REG_CMD && avs_writedata[2:0] == code;
  endsequence
  sequence s_one_busy;
    held ##2 rd_free;
  endsequence
  AST_COMPLEMENT_TIME: assert property (s_cmd(3'h1) |=> s_one_busy)
    else $error("complement did not end after one busy cycle");
  AST_FIXED_ADD_TIME: assert property (s_cmd(3'h3) |=> s_one_busy)
    else $error("fixed-point add did not end after one busy cycle");
  AST_WORD_ADD_TIME: assert property (s_cmd(3'h4) |=> s_one_busy)
    else $error("word add did not end after one busy cycle");
  AST_CLEAR_CARRY_TIME: assert property
    (s_cmd(3'h2) |=> !(avs_write && avs_waitrequest) ##2 rd_free)
    else $error("clear carry kept the unit busy");
  AST_MULTIPLY_TIME: assert property (s_cmd(3'h6) |=> held ##15 held ##2 rd_free)
    else $error("binary multiply did not take sixteen cycles");
  AST_FAST_MULTIPLY_BOUND: assert property (s_cmd(3'h5) |-> ##[3:17] rd_ok)
    else $error("fast multiply step ran too long");
  AST_FAST_DIVIDE_BOUND: assert property (s_cmd(3'h7) |-> ##[3:18] rd_ok)
    else $error("fast divide step ran too long");
  AST_READ_WAITS: assert property ($rose(avs_read) |-> avs_waitrequest)
    else $error("read answered in its launch cycle");
  AST_STATUS_READ_CLEARS: assert property (rd_ok && avs_address == `BMAU_REG_IRQ_STAT |=> !irq)
    else $error("interrupt stayed high after status read");
  AST_MASK_OFF_QUIET: assert property
    (wr_ok && avs_address == `BMAU_REG_IRQ_MASK && avs_writedata[1:0] == 2'h0 |=> !irq)
    else $error("interrupt high with all sources masked");
endmodule
bind bmau_unit bmau_unit_monitor i_mon (
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .irq(irq)
);
`default_nettype wire

// *** sim/bmau_unit_tb_top.sv ***
// self-checking bench for the bcd mantissa arithmetic unit
`timescale 1ns/1ps
`default_nettype none
`include "bmau_cfg.svh"
module bmau_unit_tb_top;
  typedef struct packed {
    logic [2:0] cmd;
    logic [47:0] op1;
    logic [47:0] op2;
    logic [31:0] ab;
    logic [47:0] e2;
    logic c;
    logic [31:0] eab;
  } bmau_row_t;
  // operation, operands, {a,b}, then expected second operand, carry and {a,b}
  localparam bmau_row_t rows [13] = '{
    '{3'h3,48'h500000000000,48'h600000000000,32'h00000000,48'h100000000000,1'b1,32'h00000000},
    '{3'h3,48'h000000000001,48'h000000000009,32'h00000000,48'h000000000011,1'b0,32'h00000000},
    '{3'h3,48'h999999999999,48'h000000000001,32'h00000000,48'h000000000000,1'b1,32'h00000000},
    '{3'h4,48'h000000000000,48'h000000000001,32'h00009999,48'h000000010001,1'b0,32'h00009999},
    '{3'h4,48'h000000000000,48'h999999999000,32'h00001000,48'h000000000000,1'b1,32'h00001000},
    '{3'h1,48'h123456789012,48'h000000000001,32'h00000000,48'h999999999999,1'b0,32'h00000000},
    '{3'h5,48'h600000000000,48'h000000000000,32'hFFFF0004,48'h400000000001,1'b1,32'h00020004},
    '{3'h6,48'h000000000000,48'h000000000000,32'hFFFE0003,48'h000000000000,1'b1,32'hFFFAFFFF},
    '{3'h6,48'h000000000000,48'h000000000000,32'h80008000,48'h000000000000,1'b1,32'h00004000},
    '{3'h2,48'h000000000000,48'h123400005678,32'h00000000,48'h123400005678,1'b0,32'h00000000},
    '{3'h7,48'h300000000000,48'h200000000000,32'h1234FFFF,48'h100000000000,1'b0,32'h12340002},
    '{3'h7,48'h000000000000,48'h000000000000,32'h0000FFFF,48'h000000000000,1'b0,32'h0000000F},
    '{3'h5,48'h000000000000,48'h000000000005,32'hFFFF0000,48'h000000000005,1'b0,32'h00000000}
  };
  logic ref_clk;
  logic rst_n;
  logic [`BMAU_ADDR_W-1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [`BMAU_DATA_W-1:0] avs_writedata;
  logic [`BMAU_DATA_W-1:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic [47:0] d;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  bmau_unit i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));
  bmau_core_model i_core (.ref_clk(ref_clk), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  // 250 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // cycle ceiling cuts a hang short
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      mismatches++;
      finish_test();
    end
  end
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    logic [15:0] x;
    i_core.xfer(1'b0, a, v, x);
  endtask
  task automatic rd(input logic [3:0] a, output logic [47:0] v);
    logic [15:0] x;
    i_core.xfer(1'b1, a, 16'h0000, x);
    v = {32'h00000000, x};
  endtask
  // a mantissa spans three consecutive words, most significant first
  task automatic wm(input logic [3:0] a, input logic [47:0] m);
    for (int i = 0; i < 3; i++) begin
      wr(a + 4'(i), m[47-16*i -: 16]);
    end
  endtask
  task automatic rm(input logic [3:0] a, output logic [47:0] m);
    logic [47:0] v;
    for (int i = 0; i < 3; i++) begin
      rd(a + 4'(i), v);
      m[47-16*i -: 16] = v[15:0];
    end
  endtask
  // start an operation; reading the command word stalls until it ends
  task automatic op(input logic [2:0] c, output logic [47:0] v);
    wr(`BMAU_REG_CMD, {13'h0000, c});
    rd(`BMAU_REG_CMD, v);
  endtask
  // interrupt level is looked at once the edge's updates have landed
  task automatic chk_irq(input logic e);
    @(negedge ref_clk);
    chk({47'h0, irq}, {47'h0, e});
  endtask
  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // reset, table of operations, then exponents, unmapped word and interrupt
  initial begin
    rst_n = 1'b0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    rm(`BMAU_REG_OP2_MHI, d);
    chk(d, 48'h000000000000);
    rd(`BMAU_REG_ACC_B, d);
    chk(d, 48'h000000000000);
    rd(`BMAU_REG_IRQ_MASK, d);
    chk(d, 48'h000000000000);
    $display("reset test done");
    wr(`BMAU_REG_OP1_EXP, 16'h1234);
    wr(`BMAU_REG_OP2_EXP, 16'h8765);
    foreach (rows[i]) begin
      wm(`BMAU_REG_OP1_MHI, rows[i].op1);
      wm(`BMAU_REG_OP2_MHI, rows[i].op2);
      wr(`BMAU_REG_ACC_A, rows[i].ab[31:16]);
      wr(`BMAU_REG_ACC_B, rows[i].ab[15:0]);
      op(rows[i].cmd, d);
      chk(d, {47'h0, rows[i].c});
      rm(`BMAU_REG_OP2_MHI, d);
      chk(d, rows[i].e2);
      rd(`BMAU_REG_ACC_A, d);
      chk(d, {32'h0, rows[i].eab[31:16]});
      rd(`BMAU_REG_ACC_B, d);
      chk(d, {32'h0, rows[i].eab[15:0]});
      $display("row %0d done", i);
    end
    rd(`BMAU_REG_OP1_EXP, d);
    chk(d, 48'h000000001234);
    rd(`BMAU_REG_OP2_EXP, d);
    chk(d, 48'h000000008765);
    wr(4'hD, 16'hBEEF);
    rd(4'hD, d);
    chk(d, 48'h000000000000);
    $display("exponent and unmapped test done");
    rd(`BMAU_REG_IRQ_STAT, d);
    chk(d, 48'h000000000003);
    // the empty command code must neither move the carry nor raise a completion
    op(3'h0, d);
    chk(d, 48'h000000000000);
    rd(`BMAU_REG_IRQ_STAT, d);
    chk(d, 48'h000000000000);
    wr(`BMAU_REG_IRQ_MASK, 16'h0001);
    op(3'h2, d);
    chk(d, 48'h000000000000);
    chk_irq(1'b1);
    rd(`BMAU_REG_IRQ_STAT, d);
    chk(d, 48'h000000000001);
    chk_irq(1'b0);
    op(3'h2, d);
    chk_irq(1'b1);
    wr(`BMAU_REG_IRQ_MASK, 16'h0000);
    chk_irq(1'b0);
    rd(`BMAU_REG_IRQ_STAT, d);
    chk(d, 48'h000000000001);
    $display("interrupt test done");
    // reset in mid-run drops a pending interrupt and clears mask, status and operands
    wr(`BMAU_REG_IRQ_MASK, 16'h0001);
    op(3'h2, d);
    chk_irq(1'b1);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    chk_irq(1'b0);
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(`BMAU_REG_IRQ_STAT, d);
    chk(d, 48'h000000000000);
    rd(`BMAU_REG_IRQ_MASK, d);
    chk(d, 48'h000000000000);
    rm(`BMAU_REG_OP2_MHI, d);
    chk(d, 48'h000000000000);
    $display("mid-run reset test done");
    finish_test();
  end
endmodule
`default_nettype wire
